// *** dv/ssc_adc_model.sv ***
`timescale 1ns/10ps
`include "ssc_map.svh"
// Converter stand-in: local value for the first channel slot, remote value after
module ssc_adc_model #(
  parameter int unsigned CHAN_CYCLES = 4
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     adc_enable,
  input  wire logic [`SSC_RESULT_W-1:0] loc_val,
  input  wire logic [`SSC_RESULT_W-1:0] rem_val,
  output logic      [`SSC_RESULT_W-1:0] adc_data
);
  int unsigned cnt_reg;
  logic        junk_reg;
  always_ff @(posedge clk) begin
    cnt_reg  <= (srst || !adc_enable) ? 0 : cnt_reg + 1;
    junk_reg <= srst ? 1'b0 : !junk_reg;
  end
  // A disabled converter shows a toggling pattern, never a stale result
  assign adc_data = adc_enable ? ((cnt_reg < CHAN_CYCLES) ? loc_val : rem_val)
                               : {`SSC_RESULT_W{junk_reg}};
endmodule : ssc_adc_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "ssc_map.svh"
module tb;
  localparam int unsigned CH  = 8;
  localparam int unsigned PER = 32;
  logic                     clk, srst, standby_pin_n, halt_bit, one_shot, seen;
  logic                     adc_enable, busy, hw_standby, sw_standby, timeout_enable, seq_done;
  logic [`SSC_RESULT_W-1:0] adc_data, loc_val, rem_val, local_result, remote_result;
  int                       errors, n_tests;
  ssc_standby_ctrl #(.CHAN_CYCLES(CH), .PERIOD_CYCLES(PER)) ssc_standby_ctrl_inst (
    .clk(clk), .srst(srst), .standby_pin_n(standby_pin_n), .halt_bit(halt_bit),
    .one_shot(one_shot), .adc_data(adc_data), .adc_enable(adc_enable), .busy(busy),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .timeout_enable(timeout_enable),
    .local_result(local_result), .remote_result(remote_result), .seq_done(seq_done));
  ssc_adc_model #(.CHAN_CYCLES(CH)) ssc_adc_model_inst (.clk(clk), .srst(srst),
    .adc_enable(adc_enable), .loc_val(loc_val), .rem_val(rem_val), .adc_data(adc_data));
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task check(input logic [`SSC_RESULT_W-1:0] got, input logic [`SSC_RESULT_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bounded wait on busy (sel 0) reaching v, or on a done pulse (sel 1)
  task wait_sig(input int sel, input logic v, input int bound);
    int i;
    for (i = 0; i < bound && ((sel == 0) ? busy : seq_done) !== v; i++) step(1);
    if (((sel == 0) ? busy : seq_done) !== v) begin
      check(((sel == 0) ? busy : seq_done), v);
      give_verdict();
    end
  endtask : wait_sig
  task shot(input logic [`SSC_RESULT_W-1:0] l, input logic [`SSC_RESULT_W-1:0] r);
    loc_val  = l;
    rem_val  = r;
    one_shot = 1'b1;
    step(1);
    one_shot = 1'b0;
  endtask : shot
  task t_shot_sw();
    halt_bit = 1'b1;
    step(3);
    check(sw_standby, 1'b1);
    check(adc_enable, 1'b0);
    check(timeout_enable, 1'b0);
    shot(11'h123, 11'h456);
    check(busy, 1'b1);
    check(adc_enable, 1'b1);
    check(local_result, 11'h000);
    wait_sig(1, 1'b1, 2 * CH + 4);
    check(local_result, 11'h123);
    check(remote_result, 11'h456);
    step(2 * CH);
    check(busy, 1'b0);
    $display("Test shot_sw done");
  endtask : t_shot_sw
  task t_hw();
    standby_pin_n = 1'b0;
    step(6);
    check(hw_standby, 1'b1);
    check(timeout_enable, 1'b0);
    shot(11'h3C3, 11'h0F0);
    seen = 1'b0;
    repeat (2 * CH + 4) begin
      seen = seen | busy;
      step(1);
    end
    check(seen, 1'b0);
    halt_bit = 1'b0;
    repeat (PER + 4) begin
      seen = seen | busy | adc_enable;
      step(1);
    end
    check(seen, 1'b0);
    check(local_result, 11'h123);
    check(remote_result, 11'h456);
    $display("Test hw done");
  endtask : t_hw
  task t_auto_abort();
    loc_val = 11'h2AA;
    rem_val = 11'h155;
    standby_pin_n = 1'b1;
    wait_sig(0, 1'b1, PER + 8);
    wait_sig(1, 1'b1, 2 * CH + 4);
    check(local_result, 11'h2AA);
    check(remote_result, 11'h155);
    check(timeout_enable, 1'b1);
    loc_val = 11'h7FF;
    rem_val = 11'h001;
    wait_sig(0, 1'b1, PER + 4);
    standby_pin_n = 1'b0;
    wait_sig(0, 1'b0, 6);
    check(adc_enable, 1'b0);
    check(local_result, 11'h2AA);
    standby_pin_n = 1'b1;
    wait_sig(0, 1'b1, PER + 8);
    halt_bit = 1'b1;
    step(2);
    check(busy, 1'b0);
    check(sw_standby, 1'b1);
    check(remote_result, 11'h155);
    $display("Test auto_abort done");
  endtask : t_auto_abort
  task t_remote_abort();
    shot(11'h111, 11'h222);
    check(busy, 1'b1);
    // Pin low reaches the core in the very last remote cycle
    step(CH + 3);
    check(local_result, 11'h111);
    standby_pin_n = 1'b0;
    wait_sig(0, 1'b0, 6);
    check(remote_result, 11'h155);
    check(seq_done, 1'b0);
    check(adc_enable, 1'b0);
    check(hw_standby, 1'b1);
    standby_pin_n = 1'b1;
    step(6);
    check(hw_standby, 1'b0);
    $display("Test remote_abort done");
  endtask : t_remote_abort
  initial begin
    srst = 1'b1;
    standby_pin_n = 1'b1;
    halt_bit = 1'b0;
    one_shot = 1'b0;
    loc_val = 11'h000;
    rem_val = 11'h000;
    errors = 0;
    n_tests = 0;
    step(5);
    srst = 1'b0;
    step(1);
    check(timeout_enable, 1'b1);
    t_shot_sw();
    t_hw();
    t_auto_abort();
    t_remote_abort();
    give_verdict();
  end
endmodule : tb

// *** verilog/ssc_map.svh ***
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// Conversion timing: one channel measurement time and default autonomous period
`define SSC_CHAN_TIME_US   60000
`define SSC_CLK_MHZ        20
`define SSC_CHAN_CYCLES    (`SSC_CHAN_TIME_US * `SSC_CLK_MHZ)
`define SSC_PERIOD_US      250000
`define SSC_PERIOD_CYCLES  (`SSC_PERIOD_US * `SSC_CLK_MHZ)
`define SSC_RESULT_W       11
`define SSC_RESULT_RESET   11'h000
`define SSC_CNT_W          32

`endif

// *** verilog/ssc_pkg.sv ***
package ssc_pkg;
  typedef enum logic [3:0] {
    SSC_IDLE   = 4'b0001,
    SSC_LOCAL  = 4'b0010,
    SSC_REMOTE = 4'b0100,
    SSC_WAIT   = 4'b1000
  } ssc_state_t;
endpackage : ssc_pkg

// *** verilog/ssc_standby_ctrl.sv ***
`timescale 1ns/10ps
`include "ssc_map.svh"

module ssc_standby_ctrl #(
  parameter int unsigned CHAN_CYCLES   = `SSC_CHAN_CYCLES,
  parameter int unsigned PERIOD_CYCLES = `SSC_PERIOD_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       standby_pin_n,
  input  wire logic                       halt_bit,
  input  wire logic                       one_shot,
  input  wire logic [`SSC_RESULT_W-1:0]   adc_data,
  output logic                            adc_enable,
  output logic                            busy,
  output logic                            hw_standby,
  output logic                            sw_standby,
  output logic                            timeout_enable,
  output logic [`SSC_RESULT_W-1:0]        local_result,
  output logic [`SSC_RESULT_W-1:0]        remote_result,
  output logic                            seq_done
);
  // Refused at elaboration: a zero channel time or a period shorter than one sequence
  if (CHAN_CYCLES < 1 || PERIOD_CYCLES < 2 * CHAN_CYCLES) begin : g_bad_timing
    $error("ssc_standby_ctrl: period must cover two channel times");
  end

  ssc_pkg::ssc_state_t state_reg;
  ssc_pkg::ssc_state_t state_next;
  logic [`SSC_CNT_W-1:0] chan_cnt_reg;
  logic [`SSC_CNT_W-1:0] period_cnt_reg;
  logic                  pin_level;
  logic                  shot_pend_reg;

  ssc_sync u_sync (
    .clk       (clk),
    .srst      (srst),
    .pin_in    (standby_pin_n),
    .level_out (pin_level)
  );

  function automatic logic is_conv(input ssc_pkg::ssc_state_t s);
    return (s == ssc_pkg::SSC_LOCAL) || (s == ssc_pkg::SSC_REMOTE);
  endfunction : is_conv

  wire hw_standby_pin_n     = ~pin_level;
  wire sw_standby_pin_n     = halt_bit & ~hw_standby_pin_n;
  wire any_standby_pin_n    = hw_standby_pin_n | halt_bit;
  wire chan_done   = (chan_cnt_reg == CHAN_CYCLES[`SSC_CNT_W-1:0] - 1'b1);
  wire period_done = (period_cnt_reg >= PERIOD_CYCLES[`SSC_CNT_W-1:0] - 1'b1);
  // A pin-held standby drops every software request, shot or autonomous
  wire shot_take   = (one_shot | shot_pend_reg) & halt_bit & ~hw_standby_pin_n;
  wire auto_take   = ~any_standby_pin_n & period_done;
  wire converting  = is_conv(state_reg);
  wire conv_next   = is_conv(state_next);
  wire seq_start   = (state_next == ssc_pkg::SSC_LOCAL) && (state_reg != ssc_pkg::SSC_LOCAL);
  // A pin standby seen in the last remote cycle is still an abort, so nothing is stored
  wire remote_end  = (state_reg == ssc_pkg::SSC_REMOTE) && chan_done && !hw_standby_pin_n
                     && (!halt_bit || shot_pend_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssc_pkg::SSC_IDLE: begin
        if (shot_take || auto_take) begin
          state_next = ssc_pkg::SSC_LOCAL;
        end
      end
      ssc_pkg::SSC_LOCAL: begin
        if (hw_standby_pin_n || (halt_bit && !shot_pend_reg)) begin
          state_next = ssc_pkg::SSC_IDLE;
        end else if (chan_done) begin
          state_next = ssc_pkg::SSC_REMOTE;
        end
      end
      ssc_pkg::SSC_REMOTE: begin
        if (hw_standby_pin_n || (halt_bit && !shot_pend_reg)) begin
          state_next = ssc_pkg::SSC_IDLE;
        end else if (chan_done) begin
          state_next = halt_bit ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_WAIT;
        end
      end
      ssc_pkg::SSC_WAIT: begin
        if (any_standby_pin_n) begin
          state_next = ssc_pkg::SSC_IDLE;
        end else if (period_done) begin
          state_next = ssc_pkg::SSC_LOCAL;
        end
      end
      default: state_next = ssc_pkg::SSC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ssc_pkg::SSC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Shot pending marks a sequence started by single-shot, so the halt bit does not abort it
  always_ff @(posedge clk) begin
    if (srst) begin
      shot_pend_reg <= 1'b0;
    end else if (hw_standby_pin_n || !halt_bit) begin
      shot_pend_reg <= 1'b0;
    end else if (one_shot && !converting) begin
      shot_pend_reg <= 1'b1;
    end else if (state_reg == ssc_pkg::SSC_REMOTE && chan_done) begin
      shot_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_next != state_reg) begin
      chan_cnt_reg <= '0;
    end else if (converting) begin
      chan_cnt_reg <= chan_cnt_reg + 1'b1;
    end
  end

  // Period counter runs from the start of each autonomous sequence
  always_ff @(posedge clk) begin
    if (srst || any_standby_pin_n || seq_start) begin
      period_cnt_reg <= '0;
    end else if (!period_done) begin
      period_cnt_reg <= period_cnt_reg + 1'b1;
    end
  end

  // Results load only on a channel's natural end; an abort never writes them
  always_ff @(posedge clk) begin
    if (srst) begin
      local_result  <= `SSC_RESULT_RESET;
      remote_result <= `SSC_RESULT_RESET;
    end else if (state_reg == ssc_pkg::SSC_LOCAL && state_next == ssc_pkg::SSC_REMOTE) begin
      local_result  <= adc_data;
    end else if (remote_end) begin
      remote_result <= adc_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq_done <= 1'b0;
    end else begin
      seq_done <= remote_end;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      adc_enable     <= 1'b0;
      busy           <= 1'b0;
      hw_standby     <= 1'b0;
      sw_standby     <= 1'b0;
      timeout_enable <= 1'b1;
    end else begin
      adc_enable     <= conv_next;
      busy           <= conv_next;
      hw_standby     <= hw_standby_pin_n;
      sw_standby     <= sw_standby_pin_n;
      timeout_enable <= ~any_standby_pin_n;
    end
  end

  sequence s_seq_start;
    state_reg == ssc_pkg::SSC_IDLE && state_next == ssc_pkg::SSC_LOCAL;
  endsequence
  sequence s_abort_req;
    converting && hw_standby_pin_n;
  endsequence
  sequence s_idle_stopped;
    state_reg == ssc_pkg::SSC_IDLE && !busy;
  endsequence

  a_hw_stops_adc: assert property (@(posedge clk) disable iff (srst)
    hw_standby_pin_n |=> !adc_enable && !busy)
    else $error("adc running in hardware standby");
  a_sw_stops_auto: assert property (@(posedge clk) disable iff (srst)
    halt_bit && !shot_pend_reg && !one_shot |=> !adc_enable)
    else $error("adc running in software standby without shot");
  a_timeout_off: assert property (@(posedge clk) disable iff (srst)
    (hw_standby_pin_n || halt_bit) |=> !timeout_enable)
    else $error("timeout enabled during standby");
  a_shot_starts: assert property (@(posedge clk) disable iff (srst)
    state_reg == ssc_pkg::SSC_IDLE && one_shot && halt_bit && !hw_standby_pin_n |-> s_seq_start)
    else $error("single shot did not start a sequence");
  a_shot_holds: assert property (@(posedge clk) disable iff (srst)
    converting && shot_pend_reg && !hw_standby_pin_n && !remote_end |=> converting)
    else $error("single shot sequence cut short without pin standby");
  a_hw_shot_ignored: assert property (@(posedge clk) disable iff (srst)
    hw_standby_pin_n && state_reg == ssc_pkg::SSC_IDLE |-> state_next == ssc_pkg::SSC_IDLE)
    else $error("conversion started in hardware standby");
  a_abort_now: assert property (@(posedge clk) disable iff (srst)
    s_abort_req |=> s_idle_stopped)
    else $error("sequence not aborted by standby");
  a_abort_keeps: assert property (@(posedge clk) disable iff (srst)
    s_abort_req |=> $stable(local_result) && $stable(remote_result))
    else $error("results changed on abort");
  a_local_hold: assert property (@(posedge clk) disable iff (srst)
    !(state_reg == ssc_pkg::SSC_LOCAL && state_next == ssc_pkg::SSC_REMOTE)
      |=> $stable(local_result))
    else $error("local result changed outside a local channel end");
  a_busy_tracks: assert property (@(posedge clk) disable iff (srst)
    busy == converting && (!busy || (adc_enable && !hw_standby)))
    else $error("busy does not follow conversion");
  a_done_idle: assert property (@(posedge clk) disable iff (srst)
    seq_done |-> !busy)
    else $error("busy still high after a finished sequence");
  a_free_run: assert property (@(posedge clk) disable iff (srst)
    state_reg == ssc_pkg::SSC_IDLE && !hw_standby_pin_n && !halt_bit && period_done |=> busy)
    else $error("autonomous conversion not resumed");
endmodule : ssc_standby_ctrl

// *** verilog/ssc_sync.sv ***
`timescale 1ns/10ps
// Three-stage synchroniser; the level changes once stages two and three agree
module ssc_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stage_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage_reg <= 3'h7;
    end else begin
      stage_reg <= {stage_reg[1:0], pin_in};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      level_out <= 1'b1;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_out <= stage_reg[2];
    end
  end
endmodule : ssc_sync
